// ### rtl/vfr_consts.vh
// constants for the output voltage fault response block
`ifndef VFR_CONSTS_VH
`define VFR_CONSTS_VH

// command codes
`define VFR_CMD_CLEAR_FAULTS 8'h03
`define VFR_CMD_OV_LIMIT 8'h40
`define VFR_CMD_OV_RESPONSE 8'h41
`define VFR_CMD_UV_LIMIT 8'h44
`define VFR_PAGE_ALL 8'hff

// response byte reset value and fields
`define VFR_OV_RESP_RST 8'h80
`define VFR_RESP_ACT_BIT 7
`define VFR_RETRY_MSB 5
`define VFR_RETRY_LSB 3
`define VFR_DELAY_MSB 2
`define VFR_DELAY_LSB 0
`define VFR_RETRY_FOREVER 3'h7

// strap scaling, limit = strap * num / den
`define VFR_UV_NUM 5'h11
`define VFR_UV_DEN 5'h14
`define VFR_OV_NUM 5'h0b
`define VFR_OV_DEN 5'h0a
`define VFR_LIMIT_MAX 16'hffff

// retry time unit
`define VFR_RETRY_UNIT_MS 35
`define VFR_CLK_KHZ 40000

// fault handler states
`define VFR_ST_RUN 2'h0
`define VFR_ST_WAIT 2'h1
`define VFR_ST_LATCH 2'h2

`endif

// ### rtl/vfr_fault_top.v
// per-page output overvoltage response and undervoltage qualification
// Behaviour
// - response codes 00/01 unused; 10/11 disable output, then apply retry mode
// - fault pulls alert low and sets status bit until clear-faults command
// - retry 000 keeps output off until device restart; 001-110 unused
// - retry 111 restarts repeatedly until commanded off, bias lost, other fault
// - attempt starts spaced by (delay + 1) times 35ms, 35ms to 280ms
// - response byte per page, read/write, resets to 80h
// - undervoltage ignored while ramping, before output good, or when off
// - undervoltage limit per page, 16-bit unsigned, 2^-13 volt per count
// - undervoltage limit resets to 0.85 times the strapped output voltage
// - overvoltage limit same format, resets to 1.10 times strapped voltage
`timescale 1ns/1ps
`default_nettype none
`include "vfr_consts.vh"

module vfr_fault_top
#(
   parameter NP = 2,
   parameter TCW = 21,
   parameter [TCW-1:0] RETRY_UNIT_CYC =
      `VFR_RETRY_UNIT_MS * `VFR_CLK_KHZ
)
(
   // clock and reset
   input wire core_clk_i,
   input wire srst_i,
   // paged command port
   input wire cmd_valid_i,
   input wire cmd_write_i,
   input wire [7:0] cmd_code_i,
   input wire [7:0] cmd_page_i,
   input wire [15:0] cmd_wdata_i,
   output reg [15:0] cmd_rdata_o,
   output reg cmd_rvalid_o,
   // strap, per page, 2^-13 volt per count
   input wire [NP*16-1:0] voltage_select_strap_i,
   // measurement and output state, per page except bias_ok_i
   input wire [NP*16-1:0] vout_meas_i,
   input wire [NP-1:0] out_enable_i,
   input wire [NP-1:0] ramping_i,
   input wire [NP-1:0] output_good_flag_i,
   input wire [NP-1:0] other_fault_i,
   input wire bias_ok_i,
   // fault outputs
   output reg alert_out_n_o,
   output reg [NP-1:0] out_disable_o,
   output reg [NP-1:0] ov_fault_status_o,
   output reg [NP-1:0] uv_fault_status_o
);

   // fault handler state codes
   localparam [1:0] ST_RUN = `VFR_ST_RUN;
   localparam [1:0] ST_WAIT = `VFR_ST_WAIT;
   localparam [1:0] ST_LATCH = `VFR_ST_LATCH;

   // true when a command addresses page p
   function page_hit;
      input [7:0] page;
      input integer p;
      begin
         page_hit = (page == `VFR_PAGE_ALL) || (page == p[7:0]);
      end
   endfunction

   wire [NP*8-1:0] resp_all;
   wire [NP*16-1:0] uv_all;
   wire [NP*16-1:0] ov_all;
   wire [NP-1:0] ovf_next;
   wire [NP-1:0] uvf_next;
   wire [NP-1:0] dis_next;
   wire clear_faults;

   assign clear_faults = cmd_valid_i && cmd_write_i &&
                         (cmd_code_i == `VFR_CMD_CLEAR_FAULTS);

   genvar p;
   generate
      for (p = 0; p < NP; p = p + 1)
      begin : g_page
         reg [7:0] resp_reg;
         reg [15:0] uv_reg;
         reg [15:0] ov_reg;
         reg [1:0] st_reg;
         reg [1:0] st_next;
         reg dis_reg;
         reg dis_nx;
         reg ovf_reg;
         reg uvf_reg;
         reg t_start;
         reg t_clr;
         reg tbusy_reg;
         wire t_done;
         wire [15:0] meas;
         wire [15:0] strap_uv;
         wire [15:0] strap_ov;
         wire wr;
         wire en;
         wire ov_hit;
         wire uv_hit;
         wire [2:0] retry_mode;
         wire stop_retry;

         assign meas = vout_meas_i[p*16 +: 16];
         assign en = out_enable_i[p];
         assign wr = cmd_valid_i && cmd_write_i &&
                     page_hit(cmd_page_i, p);
         assign retry_mode = resp_reg[`VFR_RETRY_MSB:`VFR_RETRY_LSB];
         // strict compares: a level equal to a limit is no fault
         assign ov_hit = en && !dis_reg &&
                         (meas > ov_reg);
         assign uv_hit = en && !dis_reg && !ramping_i[p] &&
                         output_good_flag_i[p] &&
                         (meas < uv_reg);
         assign stop_retry = !en || !bias_ok_i ||
                             other_fault_i[p];

         vfr_strap_scale u_strap
         (
            .strap_i(voltage_select_strap_i[p*16 +: 16]),
            .uv_limit_o(strap_uv),
            .ov_limit_o(strap_ov)
         );

         vfr_retry_timer
         #(
            .CW(TCW),
            .UNIT_CYC(RETRY_UNIT_CYC)
         )
         u_timer
         (
            .core_clk_i(core_clk_i),
            .srst_i(srst_i),
            .start_i(t_start),
            .clr_i(t_clr),
            .delay_i(resp_reg[`VFR_DELAY_MSB:`VFR_DELAY_LSB]),
            .done_o(t_done)
         );

         // configuration registers, limits load from the strap in reset
         always @(posedge core_clk_i)
         begin
            if (srst_i)
            begin
               resp_reg <= `VFR_OV_RESP_RST;
               uv_reg <= strap_uv;
               ov_reg <= strap_ov;
            end
            else if (wr)
            begin
               if (cmd_code_i == `VFR_CMD_OV_RESPONSE)
                  resp_reg <= cmd_wdata_i[7:0];
               if (cmd_code_i == `VFR_CMD_UV_LIMIT)
                  uv_reg <= cmd_wdata_i;
               if (cmd_code_i == `VFR_CMD_OV_LIMIT)
                  ov_reg <= cmd_wdata_i;
            end
         end

         // fault handler
         always @*
         begin
            st_next = st_reg;
            dis_nx = dis_reg;
            t_start = 1'b0;
            t_clr = 1'b0;
            case (st_reg)
               ST_RUN:
               begin
                  if (!en || (clear_faults && !ov_hit))
                     t_clr = 1'b1;
                  if (ov_hit && resp_reg[`VFR_RESP_ACT_BIT])
                  begin
                     dis_nx = 1'b1;
                     if (retry_mode == `VFR_RETRY_FOREVER &&
                         !stop_retry)
                     begin
                        st_next = ST_WAIT;
                        // an idle timer starts at the fault; one left
                        // running by the last attempt keeps counting
                        t_start = !tbusy_reg;
                     end
                     else
                        st_next = ST_LATCH;
                  end
               end
               ST_WAIT:
               begin
                  // clear-faults does not stop a pending restart
                  if (other_fault_i[p])
                  begin
                     st_next = ST_LATCH;
                     t_clr = 1'b1;
                  end
                  else if (!en || !bias_ok_i)
                  begin
                     st_next = ST_RUN;
                     dis_nx = 1'b0;
                     t_clr = 1'b1;
                  end
                  else if (t_done)
                  begin
                     st_next = ST_RUN;
                     dis_nx = 1'b0;
                     t_start = 1'b1;
                  end
               end
               ST_LATCH:
               begin
                  // only a device reset leaves this state
                  dis_nx = 1'b1;
               end
               default:
               begin
                  st_next = ST_RUN;
                  dis_nx = 1'b0;
               end
            endcase
         end

         // set once a retry timer is started, dropped when it is cleared;
         // without it a first fault would wait on a timer that never ran
         always @(posedge core_clk_i)
         begin
            if (srst_i || t_clr)
               tbusy_reg <= 1'b0;
            else if (t_start)
               tbusy_reg <= 1'b1;
         end

         always @(posedge core_clk_i)
         begin
            if (srst_i)
            begin
               st_reg <= ST_RUN;
               dis_reg <= 1'b0;
               ovf_reg <= 1'b0;
               uvf_reg <= 1'b0;
            end
            else
            begin
               st_reg <= st_next;
               dis_reg <= dis_nx;
               ovf_reg <= ovf_next[p];
               uvf_reg <= uvf_next[p];
            end
         end

         // a new fault wins over a clear in the same cycle
         assign ovf_next[p] = (ovf_reg && !clear_faults) || ov_hit;
         assign uvf_next[p] = (uvf_reg && !clear_faults) || uv_hit;
         assign dis_next[p] = dis_nx;
         assign resp_all[p*8 +: 8] = resp_reg;
         assign uv_all[p*16 +: 16] = uv_reg;
         assign ov_all[p*16 +: 16] = ov_reg;
      end
   endgenerate

   // outputs and read port
   always @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         alert_out_n_o <= 1'b1;
         out_disable_o <= {NP{1'b0}};
         ov_fault_status_o <= {NP{1'b0}};
         uv_fault_status_o <= {NP{1'b0}};
         cmd_rdata_o <= 16'h0000;
         cmd_rvalid_o <= 1'b0;
      end
      else
      begin
         alert_out_n_o <= ~(|{ovf_next, uvf_next});
         out_disable_o <= dis_next;
         ov_fault_status_o <= ovf_next;
         uv_fault_status_o <= uvf_next;
         cmd_rvalid_o <= cmd_valid_i && !cmd_write_i;
         if (cmd_valid_i && !cmd_write_i)
         begin
            cmd_rdata_o <= 16'h0000;
            if (cmd_page_i < NP)
            begin
               case (cmd_code_i)
                  `VFR_CMD_OV_RESPONSE:
                     cmd_rdata_o <= {8'h00,
                        resp_all[cmd_page_i*8 +: 8]};
                  `VFR_CMD_UV_LIMIT:
                     cmd_rdata_o <= uv_all[cmd_page_i*16 +: 16];
                  `VFR_CMD_OV_LIMIT:
                     cmd_rdata_o <= ov_all[cmd_page_i*16 +: 16];
                  default:
                     cmd_rdata_o <= 16'h0000;
               endcase
            end
         end
      end
   end

endmodule // vfr_fault_top
`default_nettype wire

// ### rtl/vfr_retry_timer.v
// retry delay timer: (delay + 1) units from start, then done
`timescale 1ns/1ps
`default_nettype none
`include "vfr_consts.vh"

module vfr_retry_timer
#(
   parameter CW = 21,
   parameter [CW-1:0] UNIT_CYC = 21'd1400000
)
(
   // clock and reset
   input wire core_clk_i,
   input wire srst_i,
   // control
   input wire start_i,
   input wire clr_i,
   input wire [2:0] delay_i,
   // status
   output reg done_o
);

   reg [CW-1:0] cnt_reg;
   reg [2:0] step_reg;
   reg run_reg;

   always @(posedge core_clk_i)
   begin
      if (srst_i || clr_i)
      begin
         cnt_reg <= {CW{1'b0}};
         step_reg <= 3'h0;
         run_reg <= 1'b0;
         done_o <= 1'b0;
      end
      else if (start_i)
      begin
         cnt_reg <= {CW{1'b0}};
         step_reg <= 3'h0;
         run_reg <= 1'b1;
         done_o <= 1'b0;
      end
      else if (run_reg)
      begin
         if (cnt_reg == UNIT_CYC - 1'b1)
         begin
            cnt_reg <= {CW{1'b0}};
            if (step_reg == delay_i)
            begin
               run_reg <= 1'b0;
               done_o <= 1'b1;
            end
            else
               step_reg <= step_reg + 3'h1;
         end
         else
            cnt_reg <= cnt_reg + 1'b1;
      end
   end

endmodule // vfr_retry_timer
`default_nettype wire

// ### rtl/vfr_strap_scale.v
// derives reset limits from the voltage select strap
`timescale 1ns/1ps
`default_nettype none
`include "vfr_consts.vh"

module vfr_strap_scale
(
   // strap value, same 2^-13 volt scaling as the limits
   input wire [15:0] strap_i,
   // derived limits
   output wire [15:0] uv_limit_o,
   output wire [15:0] ov_limit_o
);

   wire [20:0] uv_prod;
   wire [20:0] ov_prod;
   wire [20:0] uv_quot;
   wire [20:0] ov_quot;

   assign uv_prod = {5'h00, strap_i} * {16'h0000, `VFR_UV_NUM};
   assign ov_prod = {5'h00, strap_i} * {16'h0000, `VFR_OV_NUM};
   assign uv_quot = uv_prod / {16'h0000, `VFR_UV_DEN};
   assign ov_quot = ov_prod / {16'h0000, `VFR_OV_DEN};
   assign uv_limit_o = uv_quot[15:0];
   // overflow above full scale saturates
   assign ov_limit_o = (|ov_quot[20:16]) ? `VFR_LIMIT_MAX :
                       ov_quot[15:0];

endmodule // vfr_strap_scale
`default_nettype wire

// ### sim/tb.sv
// self-checking bench for the output fault response block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   wire valid, wr_en, rvalid, alert_n;
   wire [7:0] code, page;
   wire [15:0] wdata, rdata;
   wire [1:0] dis, ovs, uvs;
   logic [31:0] strap = {16'h4000, 16'h2000};
   logic [31:0] meas = {16'h4000, 16'h2000};
   logic [1:0] en = 2'h3;
   logic [1:0] ramp = 2'h0;
   logic [1:0] good = 2'h1;
   logic bias = 1'b1;
   logic [1:0] oflt = 2'h0;
   int bad_count = 0;
   int checked = 0;
   logic [15:0] q;
   logic rv;
   always #12.5 clk = ~clk;
   vfr_host_model u_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
      .valid_o(valid), .write_o(wr_en), .code_o(code), .page_o(page),
      .wdata_o(wdata));
   vfr_fault_top #(.NP(2), .TCW(21), .RETRY_UNIT_CYC(21'd8)) u_dut (
      .core_clk_i(clk), .srst_i(srst), .cmd_valid_i(valid),
      .cmd_write_i(wr_en), .cmd_code_i(code), .cmd_page_i(page),
      .cmd_wdata_i(wdata), .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid),
      .voltage_select_strap_i(strap), .vout_meas_i(meas),
      .out_enable_i(en), .ramping_i(ramp), .output_good_flag_i(good),
      .other_fault_i(oflt), .bias_ok_i(bias), .alert_out_n_o(alert_n),
      .out_disable_o(dis), .ov_fault_status_o(ovs),
      .uv_fault_status_o(uvs));
   task test_done;
      begin
         if (bad_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      begin
         checked++;
         if (got !== exp)
         begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task automatic cyc(input int n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task automatic wr(input logic [7:0] c, p, input logic [15:0] d);
      u_host.xfer(1'b1, c, p, d, q, rv);
   endtask
   task automatic rd(input logic [7:0] c, p, input logic [15:0] e);
      begin
         u_host.xfer(1'b0, c, p, 16'h0000, q, rv);
         chk({rv, q}, {1'b1, e});
      end
   endtask
   task automatic rst;
      begin
         srst = 1'b1;
         cyc(2);
         srst = 1'b0;
      end
   endtask
   // state of page 0 as alert, disable, status
   function automatic logic [16:0] st0();
      return {14'h0, alert_n, dis[0], ovs[0]};
   endfunction
   task t_defaults;
      begin
         rd(8'h41, 8'h00, 16'h0080);
         rd(8'h41, 8'h01, 16'h0080);
         rd(8'h44, 8'h00, 16'h1b33);
         rd(8'h44, 8'h01, 16'h3666);
         rd(8'h40, 8'h00, 16'h2333);
      end
   endtask
   task t_regs;
      begin
         wr(8'h44, 8'h01, 16'h1234);
         rd(8'h44, 8'h01, 16'h1234);
         wr(8'h44, 8'h02, 16'hffff);
         rd(8'h44, 8'h01, 16'h1234);
         wr(8'h40, 8'hff, 16'h5000);
         rd(8'h40, 8'h01, 16'h5000);
         wr(8'h40, 8'h00, 16'h2333);
         rd(8'h40, 8'h00, 16'h2333);
         wr(8'h41, 8'h00, 16'hff5a);
         rd(8'h41, 8'h00, 16'h005a);
         rd(8'h41, 8'h01, 16'h0080);
         rd(8'h77, 8'h00, 16'h0000);
      end
   endtask
   task t_unused;
      begin
         meas[15:0] = 16'h3000;
         cyc(3);
         chk(st0(), 17'h1);
         meas[15:0] = 16'h2000;
         wr(8'h03, 8'h00, 16'h0000);
         cyc(1);
         chk(st0(), 17'h4);
      end
   endtask
   task t_latch;
      logic [7:0] resp [2] = '{8'h80, 8'hd0};
      begin
         for (int i = 0; i < 2; i++)
         begin
            rst();
            wr(8'h41, 8'h00, {8'h00, resp[i]});
            meas[15:0] = 16'h3000;
            cyc(2);
            chk(st0(), 17'h3);
            meas[15:0] = 16'h2000;
            cyc(40);
            wr(8'h03, 8'h00, 16'h0000);
            cyc(1);
            chk(st0(), 17'h6);
         end
         rst();
      end
   endtask
   task automatic wait_drop(output int n);
      begin
         n = 0;
         while (dis[0] !== 1'b0 && n < 40)
         begin
            cyc(1);
            n++;
         end
         if (n == 40)
         begin
            bad_count++;
            $display("[ERR] %0t output never restarted", $time);
            test_done();
         end
      end
   endtask
   task t_retry;
      int n;
      begin
         wr(8'h41, 8'h00, 16'h00f9);
         meas[15:0] = 16'h3000;
         cyc(1);
         meas[15:0] = 16'h2000;
         // two units of 8 cycles plus one cycle for the timer flag
         wait_drop(n);
         chk(n[16:0], 17'h11);
         meas[15:0] = 16'h3000;
         cyc(2);
         chk({16'h0, dis[0]}, 17'h1);
         // a refault waits from the attempt start, not from the fault
         wait_drop(n);
         chk(n[16:0], 17'hf);
         cyc(1);
         chk({16'h0, dis[0]}, 17'h1);
         bias = 1'b0;
         meas[15:0] = 16'h2000;
         cyc(2);
         chk({16'h0, dis[0]}, 17'h0);
         bias = 1'b1;
         meas[15:0] = 16'h3000;
         cyc(2);
         chk({16'h0, dis[0]}, 17'h1);
         en[0] = 1'b0;
         meas[15:0] = 16'h2000;
         cyc(2);
         chk({16'h0, dis[0]}, 17'h0);
         en[0] = 1'b1;
         meas[15:0] = 16'h3000;
         cyc(2);
         oflt[0] = 1'b1;
         meas[15:0] = 16'h2000;
         cyc(40);
         chk({16'h0, dis[0]}, 17'h1);
         oflt[0] = 1'b0;
         rst();
      end
   endtask
   task t_uv;
      logic [2:0] m [4] = '{3'b100, 3'b111, 3'b001, 3'b101};
      begin
         meas[31:16] = 16'h3000;
         for (int i = 0; i < 4; i++)
         begin
            {en[1], ramp[1], good[1]} = m[i];
            cyc(3);
            chk({15'h0, alert_n, uvs[1]}, {15'h0, i != 3, i == 3});
         end
      end
   endtask
   initial
   begin
      cyc(12);
      srst = 1'b0;
      t_defaults();
      t_regs();
      t_unused();
      t_latch();
      t_retry();
      t_uv();
      test_done();
   end
endmodule // tb
`default_nettype wire

// ### sim/vfr_fault_monitor.sv
// checker for the output fault response block ports
`timescale 1ns/1ps
`default_nettype none
`include "vfr_consts.vh"
module vfr_fault_monitor
#(
   parameter NP = 2
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // command port
   input wire logic cmd_valid_i, cmd_write_i,
   input wire logic [7:0] cmd_code_i, cmd_page_i,
   input wire logic [15:0] cmd_wdata_i, cmd_rdata_o,
   input wire logic cmd_rvalid_o,
   // output state
   input wire logic [NP*16-1:0] voltage_select_strap_i, vout_meas_i,
   input wire logic [NP-1:0] out_enable_i, ramping_i,
   input wire logic [NP-1:0] output_good_flag_i, other_fault_i,
   input wire logic bias_ok_i,
   // fault outputs
   input wire logic alert_out_n_o,
   input wire logic [NP-1:0] out_disable_o, ov_fault_status_o,
   input wire logic [NP-1:0] uv_fault_status_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   wire clr_hit = cmd_valid_i && cmd_write_i &&
      cmd_code_i == `VFR_CMD_CLEAR_FAULTS;
   property p_read_answer;
      1'b1 |=> cmd_rvalid_o == $past(cmd_valid_i && !cmd_write_i);
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read answer timing wrong");
   property p_alert_level;
      alert_out_n_o == !(|{ov_fault_status_o, uv_fault_status_o});
   endproperty
   a_alert_level: assert property (p_alert_level)
      else $error("alert does not follow status");
   property p_ov_cause;
      $rose(ov_fault_status_o[0]) |->
         $past(out_enable_i[0] && !out_disable_o[0]);
   endproperty
   a_ov_cause: assert property (p_ov_cause)
      else $error("ov status set on an inactive output");
   property p_uv_mask;
      $rose(uv_fault_status_o[1]) |-> $past(out_enable_i[1] &&
         !ramping_i[1] && output_good_flag_i[1]);
   endproperty
   a_uv_mask: assert property (p_uv_mask)
      else $error("uv status set while masked");
   property p_sticky;
      ov_fault_status_o[0] && !clr_hit |=> ov_fault_status_o[0];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("ov status dropped without clear");
   property p_clear;
      clr_hit && cmd_page_i == 8'h00 && out_disable_o[0]
         |=> !ov_fault_status_o[0];
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear did not drop ov status");
   property p_dis_cause;
      $rose(out_disable_o[0]) |-> ov_fault_status_o[0];
   endproperty
   a_dis_cause: assert property (p_dis_cause)
      else $error("output disabled without ov fault");
   property p_rdata_hold;
      !cmd_rvalid_o |-> $stable(cmd_rdata_o);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without a read");
endmodule // vfr_fault_monitor
bind vfr_fault_top vfr_fault_monitor #(.NP(NP)) u_mon (.*);
`default_nettype wire

// ### sim/vfr_host_model.sv
// host model issuing paged commands to the fault block
`timescale 1ns/1ps
`default_nettype none
module vfr_host_model
(
   // clock and answer
   input wire logic clk_i,
   input wire logic [15:0] rdata_i,
   input wire logic rvalid_i,
   // command lines
   output logic valid_o,
   output logic write_o,
   output logic [7:0] code_o,
   output logic [7:0] page_o,
   output logic [15:0] wdata_o
);
   initial
   begin
      valid_o = 1'b0;
      write_o = 1'b0;
      code_o = 8'h00;
      page_o = 8'h00;
      wdata_o = 16'h0000;
   end
   // one strobed command; idle lines carry the inverse of the last value
   task automatic xfer(input logic w, input logic [7:0] c, p,
      input logic [15:0] d, output logic [15:0] q, output logic v);
      begin
         @(posedge clk_i);
         #1;
         valid_o = 1'b1;
         write_o = w;
         code_o = c;
         page_o = p;
         wdata_o = d;
         @(posedge clk_i);
         #1;
         v = rvalid_i;
         q = rdata_i;
         valid_o = 1'b0;
         write_o = ~w;
         code_o = ~c;
         page_o = ~p;
         wdata_o = ~d;
      end
   endtask
endmodule // vfr_host_model
`default_nettype wire
